//--- src/srk_consts.vh
`ifndef SRK_CONSTS_VH
`define SRK_CONSTS_VH
`define SRK_CLK_HZ 250000000
`define SRK_BAUD_300 300
`define SRK_BAUD_1200 1200
`define SRK_BAUD_9600 9600
`define SRK_BAUD_76800 76800
`define SRK_TO_CMD_S 7'd40
`define SRK_TO_KBD_S 7'd127
`define SRK_INV_MAX 8'd150
`define SRK_RING_SETTLE 8'd64
`define SRK_CH_CR 8'h0d
`define SRK_CH_LF 8'h0a
`define SRK_CH_STAR 8'h2a
`define SRK_CH_GT 8'h3e
`define SRK_CH_CTLQ 8'h11
`define SRK_CH_BS 8'h08
`define SRK_CH_DEL 8'h7f
`define SRK_CH_SP 8'h20
`define SRK_CH_ZERO 8'h30
`define SRK_CH_NINE 8'h39
`define SRK_CH_COLON 8'h3a
`define SRK_CH_A 8'h41
`define SRK_CH_E 8'h45
`define SRK_CH_M 8'h4d
`define SRK_CMD_7H 16'h3748
`define SRK_CMD_2718H 40'h3237313848
`endif

//--- src/srk_fifo.v
`timescale 1ns/100ps
module srk_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
              (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // srk_fifo

//--- src/srk_top.v
`timescale 1ns/100ps
`include "srk_consts.vh"
module srk_top #(
  parameter DIV_300 = `SRK_CLK_HZ / `SRK_BAUD_300,
  parameter DIV_1200 = `SRK_CLK_HZ / `SRK_BAUD_1200,
  parameter DIV_9600 = `SRK_CLK_HZ / `SRK_BAUD_9600,
  parameter DIV_76800 = `SRK_CLK_HZ / `SRK_BAUD_76800,
  parameter TICK_CYC = `SRK_CLK_HZ,
  parameter FIFO_DEPTH = 16
) (
  input wire ref_clk,
  input wire resetn,
  input wire rx_pin,
  input wire ring_pin,
  input wire chs_in,
  output reg chs_out,
  output reg chs_oe,
  output reg tx_pin,
  output reg modem_enable,
  output reg sync_device_enable,
  input wire [1:0] baud_sel,
  input wire program_changed,
  output reg compile_run,
  output reg log_only,
  output reg kbd_state,
  output reg kbd_valid,
  output reg [7:0] kbd_data,
  input wire kbd_ready,
  input wire prt_valid,
  input wire [7:0] prt_data,
  output reg prt_ready,
  input wire sd_req,
  input wire [3:0] sd_addr,
  output reg sd_done
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  localparam MK_PROMPT = 3'd0, MK_KPROMPT = 3'd1, MK_CRLF = 3'd2;
  localparam MK_CTLQ = 3'd3, MK_BSP = 3'd4, MK_ENTRY = 3'd5;
  localparam S_IDLE = 3'd0, S_RCHK = 3'd1, S_BAUD = 3'd2, S_CMD = 3'd3;
  localparam S_KBD = 3'd4, S_PRT = 3'd5, S_ADDR = 3'd6;

  function [7:0] msg_byte;
    input [2:0] kind;
    input [4:0] idx;
    begin
      case (kind)
        MK_CTLQ: msg_byte = `SRK_CH_CTLQ;
        MK_BSP: msg_byte = (idx == 5'd1) ? `SRK_CH_SP : `SRK_CH_BS;
        MK_ENTRY: msg_byte = `SRK_CH_CR;
        default: begin
          if (idx == 5'd0) begin
            msg_byte = `SRK_CH_CR;
          end else if (idx == 5'd1) begin
            msg_byte = `SRK_CH_LF;
          end else if (kind == MK_KPROMPT) begin
            msg_byte = `SRK_CH_GT;
          end else begin
            msg_byte = `SRK_CH_STAR;
          end
        end
      endcase
    end
  endfunction

  function valid_cmd_char;
    input [7:0] c;
    begin
      valid_cmd_char = (c >= `SRK_CH_ZERO && c <= `SRK_CH_COLON) ||
                       (c >= `SRK_CH_A && c <= `SRK_CH_M) ||
                       (c == `SRK_CH_CR);
    end
  endfunction

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  reg [1:0] rx_sync_reg, ring_sync_reg, chs_sync_reg;
  wire rx_s = rx_sync_reg[1];
  wire ring_s = ring_sync_reg[1];
  wire chs_s = chs_sync_reg[1];
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync_reg <= 2'b00;
      ring_sync_reg <= 2'b00;
      chs_sync_reg <= 2'b00;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], rx_pin};
      ring_sync_reg <= {ring_sync_reg[0], ring_pin};
      chs_sync_reg <= {chs_sync_reg[0], chs_in};
    end
  end

  // ------------------------------------------------------------------
  // Baud divisor, receiver and transmitter
  // ------------------------------------------------------------------
  reg [19:0] div;
  always @* begin
    case (baud_sel)
      2'd0: div = DIV_300[19:0];
      2'd1: div = DIV_1200[19:0];
      2'd2: div = DIV_9600[19:0];
      default: div = DIV_76800[19:0];
    endcase
  end

  // Line levels are inverted, so a high receive level is a space.
  reg rx_act_reg;
  reg [19:0] rx_cnt_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_sh_reg;
  reg rx_pend_reg;
  reg [7:0] rx_char_reg;
  reg rx_take;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 20'h00000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_pend_reg <= 1'b0;
      rx_char_reg <= 8'h00;
    end else begin
      if (rx_take) begin
        rx_pend_reg <= 1'b0;
      end
      if (!rx_act_reg) begin
        if (rx_s) begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= {1'b0, div[19:1]};
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != 20'h00000) begin
        rx_cnt_reg <= rx_cnt_reg - 20'h00001;
      end else begin
        rx_cnt_reg <= div - 20'h00001;
        rx_sh_reg <= {~rx_s, rx_sh_reg[8:1]};
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && !rx_s) begin
          rx_act_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
          rx_act_reg <= 1'b0;
          if (!rx_s) begin
            rx_pend_reg <= 1'b1;
            rx_char_reg <= rx_sh_reg[8:1];
          end
        end
      end
    end
  end

  reg tx_busy_reg, tx_line_reg;
  reg [19:0] tx_cnt_reg;
  reg [3:0] tx_bit_reg;
  reg [8:0] tx_sh_reg;
  reg tx_go;
  reg [7:0] tx_byte;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_busy_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      tx_cnt_reg <= 20'h00000;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 9'h1ff;
    end else if (!tx_busy_reg) begin
      if (tx_go) begin
        tx_busy_reg <= 1'b1;
        tx_line_reg <= 1'b0;
        tx_sh_reg <= {1'b1, tx_byte};
        tx_cnt_reg <= div - 20'h00001;
        tx_bit_reg <= 4'h0;
      end
    end else if (tx_cnt_reg != 20'h00000) begin
      tx_cnt_reg <= tx_cnt_reg - 20'h00001;
    end else if (tx_bit_reg == 4'h9) begin
      tx_busy_reg <= 1'b0;
    end else begin
      tx_cnt_reg <= div - 20'h00001;
      tx_line_reg <= tx_sh_reg[0];
      tx_sh_reg <= {1'b1, tx_sh_reg[8:1]};
      tx_bit_reg <= tx_bit_reg + 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // Keyboard character queue
  // ------------------------------------------------------------------
  wire fifo_in_ready, fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg fifo_push;
  wire fifo_pop = fifo_out_valid && (!kbd_valid || kbd_ready);
  srk_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
    .clk(ref_clk),
    .resetn(resetn),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_char_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ------------------------------------------------------------------
  // Session control and message sequencer
  // ------------------------------------------------------------------
  reg [2:0] st_reg, msg_kind_reg;
  reg [4:0] msg_idx_reg, ent_cnt_reg;
  reg msg_busy_reg, end_after_reg, mode2718_reg, star_reg;
  reg [39:0] cmd_buf_reg;
  reg [7:0] ent_mem [0:15];
  reg [7:0] inv_cnt_reg, settle_reg;
  reg [27:0] tick_reg;
  reg [6:0] sec_reg;
  reg [3:0] sd_bit_reg;
  reg [19:0] sd_cnt_reg;
  reg [3:0] sd_sh_reg;
  wire [4:0] msg_len = (msg_kind_reg == MK_CTLQ) ? 5'd1 :
                       (msg_kind_reg == MK_CRLF) ? 5'd2 :
                       (msg_kind_reg == MK_ENTRY) ? ent_cnt_reg + 5'd1 :
                       5'd3;
  wire [7:0] msg_cur = (msg_kind_reg == MK_ENTRY && msg_idx_reg != 5'd0) ?
                       ent_mem[msg_idx_reg[3:0] - 4'h1] :
                       msg_byte(msg_kind_reg, msg_idx_reg);
  wire session = (st_reg == S_BAUD) || (st_reg == S_CMD) ||
                 (st_reg == S_KBD);
  wire [6:0] to_lim = (st_reg == S_KBD) ? `SRK_TO_KBD_S : `SRK_TO_CMD_S;
  wire ch_ok = rx_pend_reg && !msg_busy_reg && !tx_busy_reg && !tx_go &&
               (st_reg != S_KBD || fifo_in_ready);
  wire [7:0] c = rx_char_reg;
  wire is_del = (c == `SRK_CH_BS) || (c == `SRK_CH_DEL);

  always @* begin
    rx_take = 1'b0;
    fifo_push = 1'b0;
    tx_go = 1'b0;
    tx_byte = msg_cur;
    if (session && ch_ok) begin
      rx_take = 1'b1;
      fifo_push = (st_reg == S_KBD);
    end else if (!session && rx_pend_reg) begin
      rx_take = 1'b1;
    end
    if (msg_busy_reg && !tx_busy_reg) begin
      tx_go = 1'b1;
    end else if (st_reg == S_PRT && prt_valid && !prt_ready && chs_s &&
                 !tx_busy_reg) begin
      tx_go = 1'b1;
      tx_byte = prt_data;
    end
  end

  always @(posedge ref_clk) begin
    if (st_reg == S_KBD && ch_ok && !is_del && c != `SRK_CH_CR &&
        ent_cnt_reg != 5'd16) begin
      ent_mem[ent_cnt_reg[3:0]] <= c;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= S_IDLE;
      msg_kind_reg <= MK_PROMPT;
      msg_idx_reg <= 5'd0;
      msg_busy_reg <= 1'b0;
      end_after_reg <= 1'b0;
      mode2718_reg <= 1'b0;
      star_reg <= 1'b0;
      ent_cnt_reg <= 5'd0;
      cmd_buf_reg <= 40'h0000000000;
      inv_cnt_reg <= 8'h00;
      settle_reg <= 8'h00;
      tick_reg <= 28'h0000000;
      sec_reg <= 7'h00;
      sd_bit_reg <= 4'h0;
      sd_cnt_reg <= 20'h00000;
      sd_sh_reg <= 4'h0;
      chs_out <= 1'b0;
      chs_oe <= 1'b0;
      tx_pin <= 1'b0;
      modem_enable <= 1'b0;
      sync_device_enable <= 1'b0;
      compile_run <= 1'b0;
      log_only <= 1'b0;
      kbd_state <= 1'b0;
      kbd_valid <= 1'b0;
      kbd_data <= 8'h00;
      prt_ready <= 1'b0;
      sd_done <= 1'b0;
    end else begin
      compile_run <= 1'b0;
      log_only <= 1'b0;
      prt_ready <= 1'b0;
      sd_done <= 1'b0;
      kbd_state <= (st_reg == S_KBD);
      tx_pin <= (st_reg == S_ADDR) ? sd_sh_reg[0] : ~tx_line_reg;
      if (fifo_pop) begin
        kbd_valid <= 1'b1;
        kbd_data <= fifo_out_data;
      end else if (kbd_ready) begin
        kbd_valid <= 1'b0;
      end
      if (tx_go && msg_busy_reg) begin
        msg_idx_reg <= msg_idx_reg + 5'd1;
        if (msg_idx_reg + 5'd1 == msg_len) begin
          msg_busy_reg <= 1'b0;
        end
      end
      if (session) begin
        if (tick_reg == TICK_CYC[27:0] - 28'h0000001) begin
          tick_reg <= 28'h0000000;
          sec_reg <= sec_reg + 7'h01;
        end else begin
          tick_reg <= tick_reg + 28'h0000001;
        end
      end
      case (st_reg)
        S_IDLE: begin
          modem_enable <= 1'b0;
          sync_device_enable <= 1'b0;
          chs_oe <= 1'b0;
          chs_out <= 1'b0;
          if (ring_s) begin
            st_reg <= S_RCHK;
            chs_out <= 1'b1;
            chs_oe <= 1'b1;
            settle_reg <= `SRK_RING_SETTLE;
          end else if (sd_req) begin
            st_reg <= S_ADDR;
            sync_device_enable <= 1'b1;
            chs_oe <= 1'b1;
            sd_sh_reg <= sd_addr;
            sd_bit_reg <= 4'h0;
            sd_cnt_reg <= div;
          end else if (prt_valid) begin
            st_reg <= S_PRT;
            sync_device_enable <= 1'b1;
          end
        end
        S_RCHK: begin
          settle_reg <= settle_reg - 8'h01;
          if (settle_reg == 8'h00) begin
            chs_out <= 1'b0;
            chs_oe <= 1'b0;
            if (ring_s) begin
              modem_enable <= 1'b1;
              st_reg <= S_BAUD;
              inv_cnt_reg <= 8'h00;
              tick_reg <= 28'h0000000;
              sec_reg <= 7'h00;
            end else begin
              st_reg <= S_IDLE;
            end
          end
        end
        S_PRT: begin
          if (tx_go) begin
            prt_ready <= 1'b1;
          end
          if (ring_s || (!prt_valid && !tx_busy_reg && !prt_ready)) begin
            st_reg <= S_IDLE;
          end
        end
        S_ADDR: begin
          if (sd_cnt_reg != 20'h00000) begin
            sd_cnt_reg <= sd_cnt_reg - 20'h00001;
          end else begin
            sd_cnt_reg <= div;
            chs_out <= ~chs_out;
            if (chs_out) begin
              sd_sh_reg <= {1'b0, sd_sh_reg[3:1]};
              sd_bit_reg <= sd_bit_reg + 4'h1;
              if (sd_bit_reg == 4'h3) begin
                st_reg <= S_IDLE;
                sd_done <= 1'b1;
              end
            end
          end
        end
        default: begin
          if (sec_reg >= to_lim && !msg_busy_reg && !tx_busy_reg) begin
            st_reg <= S_IDLE;
            modem_enable <= 1'b0;
          end
          if (end_after_reg && !msg_busy_reg && !tx_busy_reg) begin
            st_reg <= S_IDLE;
            modem_enable <= 1'b0;
            end_after_reg <= 1'b0;
          end
          if (inv_cnt_reg >= `SRK_INV_MAX) begin
            st_reg <= S_IDLE;
            modem_enable <= 1'b0;
          end
          if (session && ch_ok) begin
            tick_reg <= 28'h0000000;
            sec_reg <= 7'h00;
            msg_idx_reg <= 5'd0;
            if (st_reg == S_BAUD) begin
              if (c == `SRK_CH_CR) begin
                st_reg <= S_CMD;
                msg_kind_reg <= MK_PROMPT;
                msg_busy_reg <= 1'b1;
              end
            end else if (st_reg == S_CMD) begin
              if (!valid_cmd_char(c)) begin
                inv_cnt_reg <= inv_cnt_reg + 8'h01;
                cmd_buf_reg <= 40'h0000000000;
                msg_kind_reg <= MK_PROMPT;
                msg_busy_reg <= 1'b1;
              end else if (c != `SRK_CH_CR) begin
                cmd_buf_reg <= {cmd_buf_reg[31:0], c};
              end else begin
                cmd_buf_reg <= 40'h0000000000;
                msg_busy_reg <= 1'b1;
                msg_kind_reg <= MK_PROMPT;
                if (cmd_buf_reg == `SRK_CMD_2718H ||
                    cmd_buf_reg[15:0] == `SRK_CMD_7H) begin
                  st_reg <= S_KBD;
                  msg_kind_reg <= MK_KPROMPT;
                  mode2718_reg <= (cmd_buf_reg == `SRK_CMD_2718H);
                  ent_cnt_reg <= 5'd0;
                  star_reg <= 1'b0;
                end else if (cmd_buf_reg[7:0] == `SRK_CH_E) begin
                  msg_kind_reg <= MK_CRLF;
                  end_after_reg <= 1'b1;
                end
              end
            end else begin
              star_reg <= (c == `SRK_CH_STAR);
              if (star_reg && c == `SRK_CH_ZERO) begin
                st_reg <= S_CMD;
                compile_run <= program_changed;
                log_only <= 1'b1;
                msg_kind_reg <= MK_PROMPT;
                msg_busy_reg <= 1'b1;
              end else if (c == `SRK_CH_CR) begin
                ent_cnt_reg <= 5'd0;
                if (mode2718_reg) begin
                  msg_kind_reg <= MK_CTLQ;
                  msg_busy_reg <= 1'b1;
                end
              end else if (is_del) begin
                if (ent_cnt_reg != 5'd0) begin
                  ent_cnt_reg <= ent_cnt_reg - 5'd1;
                end
                msg_busy_reg <= 1'b1;
                msg_kind_reg <= mode2718_reg ? MK_ENTRY : MK_BSP;
              end else if (ent_cnt_reg != 5'd16) begin
                ent_cnt_reg <= ent_cnt_reg + 5'd1;
              end
            end
          end
        end
      endcase
    end
  end
endmodule // srk_top

//--- verification/serial_port_remote_keyboard_test.sv
`timescale 1ns/100ps
module serial_port_remote_keyboard_test;
  localparam int TICK = 50;
  logic ref_clk, resetn, rx_pin, ring_pin, chs_in, chs_out, chs_oe, tx_pin;
  logic modem_enable, sync_device_enable, program_changed, compile_run;
  logic log_only, kbd_state, kbd_valid, kbd_ready, prt_valid, prt_ready;
  logic sd_req, sd_done, hs, tx_chk, drain, got_stb, pc;
  logic [1:0] baud_sel;
  logic [3:0] sd_addr, a;
  logic [7:0] kbd_data, prt_data, got, c;
  logic [31:0] r;
  logic [7:0] txq[$], kq[$];
  int error_cnt = 0, checks = 0, seed = 32'h4365, w, i;
  int cr_n = 0, lo_n = 0, sd_n = 0, pr_n = 0;
  int divs[4] = '{32, 24, 16, 8};
  assign chs_in = chs_oe ? chs_out : hs;
  srk_top #(.DIV_300(32), .DIV_1200(24), .DIV_9600(16), .DIV_76800(8),
    .TICK_CYC(TICK)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .rx_pin(rx_pin), .ring_pin(ring_pin), .chs_in(chs_in),
    .chs_out(chs_out), .chs_oe(chs_oe), .tx_pin(tx_pin),
    .modem_enable(modem_enable), .sync_device_enable(sync_device_enable),
    .baud_sel(baud_sel), .program_changed(program_changed),
    .compile_run(compile_run), .log_only(log_only), .kbd_state(kbd_state),
    .kbd_valid(kbd_valid), .kbd_data(kbd_data), .kbd_ready(kbd_ready),
    .prt_valid(prt_valid), .prt_data(prt_data), .prt_ready(prt_ready),
    .sd_req(sd_req), .sd_addr(sd_addr), .sd_done(sd_done));
  srk_modem m (.ref_clk(ref_clk), .tx_pin(tx_pin),
    .modem_enable(modem_enable), .bit_cyc(divs[baud_sel]), .rx_pin(rx_pin),
    .ring_pin(ring_pin), .got(got), .got_stb(got_stb));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic put(input string s, input string e);
    for (int k = 0; k < e.len(); k++) txq.push_back(e[k]);
    for (int k = 0; k < s.len(); k++) m.send(s[k]);
  endtask
  task automatic settle();
    int n = 0;
    while (txq.size() > 0 && n < 5000) begin
      cyc(1);
      n++;
    end
    cyc(40);
    chk(8'(txq.size()), 8'h00);
  endtask
  task automatic answer(input logic [1:0] b);
    baud_sel = b;
    m.ring();
    put("\015", "\015\012*");
    settle();
  endtask
  task automatic to_run(input int lim);
    int n = 0;
    while (modem_enable && n < 9000) begin
      cyc(1);
      n++;
    end
    chk(8'(n >= (lim - 14) * TICK && n <= (lim + 1) * TICK), 8'h01);
  endtask
  // ----
  // Result watchers: link bytes, keyboard bytes and pulse counts.
  // ----
  always @(posedge ref_clk) begin
    if (got_stb && tx_chk)
      chk(got, txq.size() ? txq.pop_front() : 8'hxx);
    if (kbd_valid && kbd_ready)
      chk(kbd_data, kq.size() ? kq.pop_front() : 8'hxx);
    cr_n += compile_run;
    lo_n += log_only;
    sd_n += sd_done;
    pr_n += prt_ready;
  end
  always @(posedge ref_clk) #1 kbd_ready = drain & r[0];
  always @(posedge ref_clk) #1 r = $random(seed);
  initial begin
    cyc(90000);
    error_cnt++;
    end_sim();
  end
  initial begin
    resetn = 1'b0;
    baud_sel = 2'h3;
    {program_changed, prt_valid, sd_req, hs, drain} = 5'h00;
    {prt_data, sd_addr, tx_chk, pc} = 14'h0002;
    kbd_ready = 1'b0;
    cyc(10);
    resetn = 1'b1;
    cyc(3);
    chk(8'({tx_pin, modem_enable, sync_device_enable}), 8'h00);
    answer(2'h3);
    put("7H\015", "\015\012>");
    settle();
    chk(8'(kbd_state), 8'h01);
    for (i = 0; i < 17; i++) begin
      c = 8'h30 + 8'(r[7:0] % 10);
      kq.push_back(c);
      m.send(c);
    end
    chk(8'(kbd_valid), 8'h01);
    drain = 1'b1;
    for (w = 0; kq.size() > 0 && w < 3000; w++) cyc(1);
    drain = 1'b0;
    chk(8'(kq.size()), 8'h00);
    put("\010\015", "\010 \010");
    settle();
    program_changed = 1'b1;
    put("*0", "\015\012*");
    settle();
    chk(8'({kbd_state, cr_n[1:0], lo_n[1:0]}), 8'h05);
    put("2718H\015", "\015\012>");
    settle();
    put("56\010", "\0155");
    settle();
    put("\015", "\021");
    settle();
    program_changed = 1'b0;
    put("*0", "\015\012*");
    settle();
    chk(8'({cr_n[1:0], lo_n[1:0]}), 8'h06);
    put("E\015", "\015\012");
    settle();
    chk(8'(modem_enable), 8'h00);
    answer(2'h2);
    to_run(40);
    answer(2'h2);
    put("7H\015", "\015\012>");
    settle();
    to_run(127);
    answer(2'h3);
    tx_chk = 1'b0;
    for (i = 0; i < 150; i++) begin
      if (i == 149) chk(8'(modem_enable), 8'h01);
      m.send("z");
      cyc(300);
    end
    chk(8'(modem_enable), 8'h00);
    txq.delete();
    tx_chk = 1'b1;
    baud_sel = 2'h0;
    prt_data = r[7:0];
    prt_valid = 1'b1;
    cyc(60);
    chk(8'({sync_device_enable, pr_n[0]}), 8'h02);
    txq.push_back(prt_data);
    hs = 1'b1;
    for (w = 0; pr_n == 0 && w < 500; w++) cyc(1);
    prt_valid = 1'b0;
    settle();
    hs = 1'b0;
    baud_sel = 2'h1;
    sd_addr = r[3:0];
    sd_req = 1'b1;
    tx_chk = 1'b0;
    cyc(1);
    sd_req = 1'b0;
    i = 0;
    for (w = 0; i < 4 && w < 2000; w++) begin
      cyc(1);
      if (chs_out && !pc) begin
        a[i] = tx_pin;
        i++;
      end
      pc = chs_out;
    end
    chk(8'(a), 8'(sd_addr));
    cyc(200);
    chk(8'(sd_n), 8'h01);
    end_sim();
  end
endmodule // serial_port_remote_keyboard_test

//--- verification/srk_modem.sv
`timescale 1ns/100ps
module srk_modem (
  input wire logic ref_clk,
  input wire logic tx_pin,
  input wire logic modem_enable,
  input int bit_cyc,
  output logic rx_pin,
  output logic ring_pin,
  output logic [7:0] got,
  output logic got_stb
);
  initial begin
    rx_pin = 1'b0;
    ring_pin = 1'b0;
    got = 8'h00;
    got_stb = 1'b0;
  end
  // ----
  // Ring stays high until the answer comes or 500 cycles pass, as a modem must.
  // ----
  task ring();
    int n;
    n = 0;
    @(posedge ref_clk) #1 ring_pin = 1'b1;
    while (!modem_enable && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    #1 ring_pin = 1'b0;
  endtask
  task send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b0, ~c, 1'b1};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk) #1 rx_pin = f[i];
      repeat (bit_cyc - 1) @(posedge ref_clk);
    end
  endtask
  // ----
  // Decoder of the transmit line; a bad stop bit makes the byte unknown.
  // ----
  initial forever begin
    @(posedge ref_clk);
    if (tx_pin) begin
      repeat (bit_cyc / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge ref_clk);
        got[i] = ~tx_pin;
      end
      repeat (bit_cyc) @(posedge ref_clk);
      if (tx_pin) got = 8'hxx;
      #1 got_stb = 1'b1;
      @(posedge ref_clk) #1 got_stb = 1'b0;
    end
  end
endmodule // srk_modem

//--- verification/srk_top_sva.sv
`timescale 1ns/100ps
module srk_top_sva (
  input logic ref_clk,
  input logic resetn,
  input logic ring_pin,
  input logic chs_in,
  input logic chs_out,
  input logic chs_oe,
  input logic tx_pin,
  input logic modem_enable,
  input logic sync_device_enable,
  input logic program_changed,
  input logic compile_run,
  input logic log_only,
  input logic kbd_state,
  input logic prt_ready,
  input logic sd_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // ----
  // Ring probe holds the handshake line high, then a modem is answered.
  // ----
  sequence s_probe;
    (chs_oe && chs_out) [*8];
  endsequence
  sequence s_answer;
    ##[60:75] $rose(modem_enable);
  endsequence
  a_out_reset: assert property ($rose(resetn) |-> !tx_pin && !chs_oe
    && !modem_enable && !sync_device_enable && !kbd_state)
    else $error("outputs not quiet after reset");
  a_ring_probe: assert property ($rose(chs_oe) && ring_pin |-> s_probe)
    else $error("ring probe not held");
  a_ring_answer: assert property ($rose(chs_oe) && ring_pin |-> s_answer)
    else $error("modem not answered in time");
  a_me_on_ring: assert property ($rose(modem_enable) |-> $past(ring_pin))
    else $error("modem enable without ring");
  a_me_no_sde: assert property (modem_enable |-> !sync_device_enable)
    else $error("both enables high");
  a_prt_hs_go: assert property (prt_ready |-> sync_device_enable
    && $past(chs_in, 3))
    else $error("printer byte taken without handshake");
  a_prt_start: assert property (prt_ready |-> ##[1:3] tx_pin)
    else $error("no start bit after printer byte");
  a_compile_run: assert property (compile_run |-> log_only
    && $past(program_changed))
    else $error("compile without exit or change");
  a_kbd_exit: assert property (log_only |=> !kbd_state && !log_only)
    else $error("keyboard exit wrong");
  a_sd_done: assert property (sd_done |-> $past(sync_device_enable))
    else $error("addressing done without enable");
endmodule // srk_top_sva
bind srk_top srk_top_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
  .ring_pin(ring_pin), .chs_in(chs_in), .chs_out(chs_out),
  .chs_oe(chs_oe), .tx_pin(tx_pin), .modem_enable(modem_enable),
  .sync_device_enable(sync_device_enable),
  .program_changed(program_changed), .compile_run(compile_run),
  .log_only(log_only), .kbd_state(kbd_state), .prt_ready(prt_ready),
  .sd_done(sd_done));
